// ==== src/aks_consts.svh ====
// Constants for the lookup key selection and range check block
`ifndef AKS_CONSTS_SVH
`define AKS_CONSTS_SVH

// Sizes
`define AKS_NUM_PORTS       12
`define AKS_PORT_W          4
`define AKS_NUM_LOOKUPS     2
`define AKS_NUM_RNG         8
`define AKS_FRM_BYTES       128
`define AKS_FRM_LIMIT       9'h080
`define AKS_RAW1_BYTES      57
`define AKS_RAW2_BYTES      24
`define AKS_CHOICE_W        3
`define AKS_RTYPE_W         3
`define AKS_BOUNDS_W        32

// Payload-relative raw key offsets in bytes
`define AKS_PLUS20          9'h014
`define AKS_PLUS40          9'h028

// First nibble of the IP header in control-word frames
`define AKS_NIBBLE_V6       4'h6
`define AKS_NIBBLE_V4       4'h4

// Key choice codes in lookup_key_choice_cfg
`define AKS_CH_GENERIC      3'h0
`define AKS_CH_V4_VLAN      3'h1
`define AKS_CH_V6_VLAN      3'h2
`define AKS_CH_SEVEN        3'h3
`define AKS_CH_V4_TRANSPORT 3'h4
`define AKS_CH_V4_MISC      3'h5
`define AKS_CH_ARP          3'h6

// Raw key start position codes in raw_key_position
`define AKS_POS_LINK        2'h0
`define AKS_POS_PAYLOAD     2'h1
`define AKS_POS_PLUS20      2'h2
`define AKS_POS_PLUS40      2'h3

// Range checker type codes in range_type_cfg
`define AKS_RT_DPORT        3'h0
`define AKS_RT_SPORT        3'h1
`define AKS_RT_EITHER       3'h2
`define AKS_RT_VID          3'h3
`define AKS_RT_DSCP         3'h4
`define AKS_RT_FIELD        3'h5

`endif

// ==== src/aks_pkg.sv ====
// Types for the lookup key selection and range check block
`include "aks_consts.svh"

package aks_pkg;

	// Frame types delivered by the upstream classifier
	typedef enum logic [3:0] {
		FT_IP6_MC,
		FT_IP6_UC,
		FT_IP4_MC,
		FT_IP4_UC,
		FT_ARP,
		FT_OAM,
		FT_SNAP,
		FT_LLC,
		FT_ETYPE
	} aks_frame_type;

	// Key types handed to the match stage
	typedef enum logic [3:0] {
		KT_NONE,
		KT_GENERIC,
		KT_V4_VLAN,
		KT_V6_VLAN,
		KT_SEVEN,
		KT_V4_TRANSPORT,
		KT_V4_MISC,
		KT_ARP,
		KT_RAW1,
		KT_RAW2
	} aks_key_type;

	// Whole registered state of the block
	typedef struct packed {
		logic [1:0]                       key_valid;
		aks_key_type                      kind0;
		aks_key_type                      kind1;
		logic [1:0]                       lk_en;
		logic                             l2_zero;
		logic [`AKS_PORT_W-1:0]           port;
		logic [`AKS_NUM_RNG-1:0]          rng0;
		logic [`AKS_NUM_RNG-1:0]          rng1;
		logic [`AKS_RAW1_BYTES*8-1:0]     raw1;
		logic [`AKS_RAW2_BYTES*8-1:0]     raw2;
	} aks_state_type;

endpackage

// ==== src/aks_key_select.sv ====
// Key generation, key selection and range checkers for the two ACL lookups
`timescale 1ns/1ps
`include "aks_consts.svh"

module aks_key_select
	import aks_pkg::*;
(
	input  wire logic                                      mclk,
	input  wire logic                                      sys_rst,
	// Per-port configuration
	input  wire logic [`AKS_NUM_PORTS*2-1:0]               lookup_enable,
	input  wire logic [`AKS_NUM_PORTS*2*`AKS_CHOICE_W-1:0] lookup_key_choice_cfg,
	// Range checker configuration
	input  wire logic [`AKS_NUM_RNG*`AKS_RTYPE_W-1:0]      range_type_cfg,
	input  wire logic [`AKS_NUM_RNG*`AKS_BOUNDS_W-1:0]     range_bounds_cfg,
	input  wire logic [7:0]                                range_field_offset_cfg,
	// Frame from the upstream classifier
	input  wire logic                                      frm_valid,
	input  wire logic [`AKS_PORT_W-1:0]                    frm_port,
	input  wire aks_frame_type                             frm_type,
	input  wire logic                                      control_word_frame,
	input  wire logic                                      frm_dst_mc,
	input  wire logic                                      frm_tcp_udp,
	input  wire logic [6:0]                                frm_l3_pos,
	input  wire logic [6:0]                                frm_etype_pos,
	input  wire logic [11:0]                               frm_vid,
	input  wire logic [5:0]                                frm_dscp,
	input  wire logic [15:0]                               frm_sport,
	input  wire logic [15:0]                               frm_dport,
	input  wire logic [7:0]                                frm_data [`AKS_FRM_BYTES],
	input  wire logic [1:0]                                raw_key_enable,
	input  wire logic [1:0]                                raw_key_position,
	// Match results from the TCAM stage
	input  wire logic [1:0]                                tcam_hit,
	// Key to the TCAM stage
	output logic [1:0]                                     key_valid,
	output aks_key_type                                    key_kind_lk0,
	output aks_key_type                                    key_kind_lk1,
	output logic [`AKS_PORT_W-1:0]                         key_port,
	output logic                                           key_l2_zero,
	output logic [`AKS_NUM_RNG-1:0]                        range_flags_field_lk0,
	output logic [`AKS_NUM_RNG-1:0]                        range_flags_field_lk1,
	output logic [`AKS_RAW1_BYTES*8-1:0]                   raw_key1_data,
	output logic [`AKS_RAW2_BYTES*8-1:0]                   raw_key2_data,
	// Match results as used
	output logic [1:0]                                     match_used
);

	aks_state_type st_q;
	aks_state_type st_d;

	// Effective frame family after the control-word nibble decode
	logic        eff_v6;
	logic        eff_v4;
	logic        eff_std_ok;
	logic [3:0]  cw_nibble;
	logic [8:0]  raw_start;
	logic        raw_start_ok;
	logic [8:0]  fld_pos;
	logic [8:0]  fld_pos1;
	logic        fld_ok;
	logic [15:0] fld_value;
	logic [`AKS_NUM_RNG-1:0]          rng_hit;
	logic [`AKS_RAW1_BYTES*8-1:0]     raw_bytes;

	// The IP header sits at the payload position in control-word frames
	assign cw_nibble  = frm_data[frm_l3_pos][7:4];
	assign eff_v6     = control_word_frame ? (cw_nibble == `AKS_NIBBLE_V6)
	                  : (frm_type == FT_IP6_MC || frm_type == FT_IP6_UC);
	assign eff_v4     = control_word_frame ? (cw_nibble == `AKS_NIBBLE_V4)
	                  : (frm_type == FT_IP4_MC || frm_type == FT_IP4_UC);
	assign eff_std_ok = !control_word_frame || eff_v6 || eff_v4;

	// Raw key start; link start is refused on control-word frames
	always_comb begin
		raw_start    = {2'b00, frm_l3_pos};
		raw_start_ok = 1'b1;
		unique case (raw_key_position)
			`AKS_POS_LINK: begin
				raw_start    = 9'h000;
				raw_start_ok = !control_word_frame;
			end
			`AKS_POS_PAYLOAD: raw_start = {2'b00, frm_l3_pos};
			`AKS_POS_PLUS20:  raw_start = {2'b00, frm_l3_pos} + `AKS_PLUS20;
			`AKS_POS_PLUS40:  raw_start = {2'b00, frm_l3_pos} + `AKS_PLUS40;
		endcase
	end

	// Raw key bytes; bytes past the frame window read as zero
	genvar gi;
	generate
		for (gi = 0; gi < `AKS_RAW1_BYTES; gi++) begin : g_raw
			logic [8:0] idx;
			assign idx = raw_start + 9'(gi);
			assign raw_bytes[gi*8 +: 8] = (idx < `AKS_FRM_LIMIT) ? frm_data[idx[6:0]] : 8'h00;
		end
	endgenerate

	// Selected field: big-endian 16 bits at the shared offset past Type/Len
	assign fld_pos   = {2'b00, frm_etype_pos} + {1'b0, range_field_offset_cfg};
	assign fld_pos1  = fld_pos + 9'h001;
	assign fld_ok    = fld_pos1 < `AKS_FRM_LIMIT;
	assign fld_value = fld_ok ? {frm_data[fld_pos[6:0]], frm_data[fld_pos1[6:0]]} : 16'h0000;

	// Eight range checkers, one match bit each
	generate
		for (gi = 0; gi < `AKS_NUM_RNG; gi++) begin : g_rng
			logic [2:0]  rtype;
			logic [15:0] lo;
			logic [15:0] hi;
			logic        in_d;
			logic        in_s;
			logic        in_v;
			logic        in_q;
			logic        in_f;
			assign rtype = range_type_cfg[gi*`AKS_RTYPE_W +: `AKS_RTYPE_W];
			assign lo    = range_bounds_cfg[gi*`AKS_BOUNDS_W +: 16];
			assign hi    = range_bounds_cfg[gi*`AKS_BOUNDS_W+16 +: 16];
			// Both bounds inclusive
			assign in_d  = (frm_dport >= lo) && (frm_dport <= hi);
			assign in_s  = (frm_sport >= lo) && (frm_sport <= hi);
			assign in_v  = ({4'h0, frm_vid} >= lo) && ({4'h0, frm_vid} <= hi);
			assign in_q  = ({10'h000, frm_dscp} >= lo) && ({10'h000, frm_dscp} <= hi);
			assign in_f  = (fld_value >= lo) && (fld_value <= hi);
			always_comb begin
				rng_hit[gi] = 1'b0;  // Unknown or inapplicable types never match
				case (rtype)
					`AKS_RT_DPORT:  rng_hit[gi] = frm_tcp_udp && in_d;
					`AKS_RT_SPORT:  rng_hit[gi] = frm_tcp_udp && in_s;
					`AKS_RT_EITHER: rng_hit[gi] = frm_tcp_udp && (in_s || in_d);
					`AKS_RT_VID:    rng_hit[gi] = in_v;
					`AKS_RT_DSCP:   rng_hit[gi] = (eff_v4 || eff_v6) && in_q;
					`AKS_RT_FIELD:  rng_hit[gi] = fld_ok && in_f;
					default:        rng_hit[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Maps a configured choice onto the keys legal for the frame family
	function automatic aks_key_type pick_key(input logic [2:0] ch, input logic v6, input logic v4,
	                                         input logic mc, input logic arp);
		aks_key_type k;
		k = KT_GENERIC;  // Anything not offered falls back to the generic key
		if (v6) begin
			if (ch == `AKS_CH_V6_VLAN && mc)
				k = KT_V6_VLAN;
			else if (ch == `AKS_CH_SEVEN)
				k = KT_SEVEN;
		end else if (v4) begin
			if (ch == `AKS_CH_V4_VLAN && mc)
				k = KT_V4_VLAN;
			else if (ch == `AKS_CH_SEVEN)
				k = KT_SEVEN;
			else if (ch == `AKS_CH_V4_TRANSPORT)
				k = KT_V4_TRANSPORT;
			else if (ch == `AKS_CH_V4_MISC)
				k = KT_V4_MISC;
		end else if (arp && ch == `AKS_CH_ARP) begin
			k = KT_ARP;
		end
		return k;  // OAM, SNAP, LLC, EtherType stay generic
	endfunction

	// Next state: one frame in, one key set out a cycle later
	always_comb begin
		logic                         port_ok;
		logic                         mc;
		logic                         arp;
		logic                         raw_on;
		logic [6:0]                   cfg_idx;
		logic [2:0]                   ch;
		aks_key_type                  k;
		port_ok = frm_port < `AKS_PORT_W'(`AKS_NUM_PORTS);
		mc      = control_word_frame ? frm_dst_mc : (frm_type == FT_IP6_MC || frm_type == FT_IP4_MC);
		arp     = !control_word_frame && frm_type == FT_ARP;
		raw_on  = |raw_key_enable;
		cfg_idx = 7'h00;
		ch      = `AKS_CH_GENERIC;
		k       = KT_NONE;
		st_d    = st_q;
		// Match use lasts only while the key of the frame stands
		st_d.key_valid = 2'b00;
		if (frm_valid) begin
			st_d.port    = frm_port;
			st_d.l2_zero = control_word_frame;  // Link-layer fields nulled
			st_d.raw1    = '0;
			st_d.raw2    = '0;
			st_d.rng0    = '0;
			st_d.rng1    = '0;
			for (int lk = 0; lk < `AKS_NUM_LOOKUPS; lk++) begin
				cfg_idx = 7'({frm_port, 1'(lk)}) * 7'(`AKS_CHOICE_W);
				ch      = lookup_key_choice_cfg[cfg_idx +: `AKS_CHOICE_W];
				if (raw_on) begin
					// Upstream raw key wins over the configured choice
					k = raw_key_enable[0] ? KT_RAW1 : KT_RAW2;
				end else if (eff_std_ok) begin
					k = pick_key(ch, eff_v6, eff_v4, mc, arp);
				end else begin
					k = KT_NONE;
				end
				st_d.lk_en[lk] = port_ok && lookup_enable[{frm_port, 1'(lk)}];
				// No key without enable; refused raw start gives no key either
				st_d.key_valid[lk] = st_d.lk_en[lk] && k != KT_NONE
				                   && !(raw_on && !raw_start_ok);
				if (lk == 0)
					st_d.kind0 = k;
				else
					st_d.kind1 = k;
				// Range bits only ride on the seven-field and transport keys
				if (k == KT_SEVEN || k == KT_V4_TRANSPORT) begin
					if (lk == 0)
						st_d.rng0 = rng_hit;
					else
						st_d.rng1 = rng_hit;
				end
			end
			if (raw_on && raw_start_ok) begin
				st_d.raw1 = raw_bytes;
				st_d.raw2 = raw_bytes[`AKS_RAW2_BYTES*8-1:0];
			end
		end
	end

	// Single state register, synchronous reset
	always_ff @(posedge mclk) begin
		if (sys_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// Outputs from the state register
	assign key_valid             = st_q.key_valid;
	assign key_kind_lk0          = st_q.kind0;
	assign key_kind_lk1          = st_q.kind1;
	assign key_port              = st_q.port;
	assign key_l2_zero           = st_q.l2_zero;
	assign range_flags_field_lk0 = st_q.rng0;
	assign range_flags_field_lk1 = st_q.rng1;
	assign raw_key1_data         = st_q.raw1;
	assign raw_key2_data         = st_q.raw2;

	// A hit on a lookup without a key is dropped here, so a disabled port never matches
	assign match_used = tcam_hit & st_q.key_valid & st_q.lk_en;

endmodule

// ==== bench/aks_tcam_model.sv ====
// Match stage stand-in answering hits for the keys it is given
`timescale 1ns/1ps
module aks_tcam_model (
	input  wire logic [1:0] key_valid,
	input  wire logic [1:0] hit_mask,
	output logic [1:0]      tcam_hit
);
	// A real match stage only answers lookups that were handed a key
	assign tcam_hit = key_valid & hit_mask;
endmodule

// ==== bench/aks_props.sv ====
// Concurrent checks on the key select block ports
`timescale 1ns/1ps
`include "aks_consts.svh"
module aks_props
	import aks_pkg::*;
(
	input wire logic          mclk,
	input wire logic          sys_rst,
	input wire logic [23:0]   lookup_enable,
	input wire logic [23:0]   range_type_cfg,
	input wire logic [255:0]  range_bounds_cfg,
	input wire logic          frm_valid,
	input wire logic [3:0]    frm_port,
	input wire aks_frame_type frm_type,
	input wire logic          control_word_frame,
	input wire logic [11:0]   frm_vid,
	input wire logic [1:0]    raw_key_enable,
	input wire logic [1:0]    tcam_hit,
	input wire logic [1:0]    key_valid,
	input wire aks_key_type   key_kind_lk0,
	input wire logic [3:0]    key_port,
	input wire logic          key_l2_zero,
	input wire logic [7:0]    range_flags_field_lk0,
	input wire logic [1:0]    match_used
);
	logic [1:0] en_now;
	logic       vid_hit;
	logic       vid_hit_q;
	// Enables of the arriving port; ports past the last one have none
	assign en_now = (frm_port < 4'hc) ? lookup_enable[frm_port*2 +: 2] : 2'h0;
	assign vid_hit = {4'h0, frm_vid} >= range_bounds_cfg[15:0] && {4'h0, frm_vid} <= range_bounds_cfg[31:16];
	// Checker 0 verdict kept for the key cycle
	always_ff @(posedge mclk) vid_hit_q <= vid_hit;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	AST_KEY_OFF: assert property (frm_valid |=> (key_valid & ~$past(en_now)) == 2'h0)
		else $error("key for a disabled lookup");
	AST_KEY_ON: assert property (frm_valid && !control_word_frame && raw_key_enable == 2'h0
		|=> key_valid == $past(en_now)) else $error("key presence differs from enables");
	AST_ONE_CYCLE: assert property (!frm_valid |=> key_valid == 2'h0)
		else $error("key without a frame");
	AST_USED: assert property ((match_used & ~(tcam_hit & key_valid)) == 2'h0)
		else $error("match used without key and hit");
	AST_GENERIC: assert property (frm_valid && !control_word_frame && raw_key_enable == 2'h0 && en_now[0]
		&& frm_type inside {FT_OAM, FT_SNAP, FT_LLC, FT_ETYPE} |=> key_kind_lk0 == KT_GENERIC)
		else $error("non-IP frame not on generic key");
	AST_RAW: assert property (frm_valid && raw_key_enable[0] && !control_word_frame && en_now[0]
		|=> key_kind_lk0 == KT_RAW1) else $error("raw key request ignored");
	AST_CW_NULL: assert property (frm_valid && control_word_frame |=> key_valid == 2'h0 || key_l2_zero)
		else $error("link fields kept on control-word frame");
	AST_PORT: assert property (frm_valid |=> key_port == $past(frm_port))
		else $error("key port differs from frame port");
	AST_FLAGS: assert property (!(key_kind_lk0 inside {KT_SEVEN, KT_V4_TRANSPORT})
		|-> range_flags_field_lk0 == 8'h00) else $error("range flags on a key without them");
	AST_VID: assert property (frm_valid && range_type_cfg[2:0] == `AKS_RT_VID ##1
		key_kind_lk0 inside {KT_SEVEN, KT_V4_TRANSPORT} |-> range_flags_field_lk0[0] == vid_hit_q)
		else $error("vid range flag wrong");
	// Main scenarios reached
	cover property (frm_valid ##1 key_valid == 2'h3);
	cover property (key_kind_lk0 == KT_RAW1);
	cover property (match_used != 2'h0);
endmodule
bind aks_key_select aks_props u_props (
	.mclk, .sys_rst, .lookup_enable, .range_type_cfg, .range_bounds_cfg, .frm_valid, .frm_port,
	.frm_type, .control_word_frame, .frm_vid, .raw_key_enable, .tcam_hit, .key_valid, .key_kind_lk0,
	.key_port, .key_l2_zero, .range_flags_field_lk0, .match_used
);

// ==== bench/tb_top.sv ====
// Self-checking bench for the key select block
`timescale 1ns/1ps
module tb_top
	import aks_pkg::*;
;
	logic          mclk, sys_rst, frm_valid, control_word_frame, frm_dst_mc, frm_tcp_udp, key_l2_zero;
	logic [23:0]   lookup_enable, range_type_cfg;
	logic [71:0]   lookup_key_choice_cfg;
	logic [255:0]  range_bounds_cfg;
	logic [7:0]    range_field_offset_cfg, range_flags_field_lk0, range_flags_field_lk1;
	logic [3:0]    frm_port, key_port;
	logic [6:0]    frm_l3_pos, frm_etype_pos;
	logic [11:0]   frm_vid;
	logic [5:0]    frm_dscp;
	logic [15:0]   frm_sport, frm_dport;
	logic [7:0]    frm_data [128];
	logic [1:0]    raw_key_enable, raw_key_position, tcam_hit, hit_mask, key_valid, match_used;
	logic [455:0]  raw_key1_data;
	logic [191:0]  raw_key2_data;
	aks_frame_type frm_type;
	aks_key_type   key_kind_lk0, key_kind_lk1;
	int            n_mismatch = 0;
	int            total_checks = 0;
	// Frame type, configured choice and the key that must result
	aks_frame_type ft_t [12] = '{FT_OAM, FT_SNAP, FT_LLC, FT_ETYPE, FT_IP4_MC, FT_IP4_UC, FT_IP4_UC,
		FT_IP4_MC, FT_IP6_MC, FT_IP6_UC, FT_ARP, FT_IP6_UC};
	logic [2:0]    ch_t [12] = '{3'h3, 3'h4, 3'h1, 3'h6, 3'h1, 3'h1, 3'h5, 3'h4, 3'h2, 3'h3, 3'h6, 3'h2};
	aks_key_type   kt_t [12] = '{KT_GENERIC, KT_GENERIC, KT_GENERIC, KT_GENERIC, KT_V4_VLAN, KT_GENERIC,
		KT_V4_MISC, KT_V4_TRANSPORT, KT_V6_VLAN, KT_SEVEN, KT_ARP, KT_GENERIC};
	logic [7:0]    nib_t [3] = '{8'h45, 8'h60, 8'h50};
	aks_key_type   kc_t [2] = '{KT_V4_TRANSPORT, KT_GENERIC};

	aks_key_select u_dut (.mclk, .sys_rst, .lookup_enable, .lookup_key_choice_cfg, .range_type_cfg,
		.range_bounds_cfg, .range_field_offset_cfg, .frm_valid, .frm_port, .frm_type, .control_word_frame,
		.frm_dst_mc, .frm_tcp_udp, .frm_l3_pos, .frm_etype_pos, .frm_vid, .frm_dscp, .frm_sport, .frm_dport,
		.frm_data, .raw_key_enable, .raw_key_position, .tcam_hit, .key_valid, .key_kind_lk0, .key_kind_lk1,
		.key_port, .key_l2_zero, .range_flags_field_lk0, .range_flags_field_lk1, .raw_key1_data,
		.raw_key2_data, .match_used);
	aks_tcam_model u_tcam (.key_valid, .hit_mask, .tcam_hit);

	// 40 MHz core clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One frame raised at the next edge and taken at the edge after; outputs read just after that answer edge
	task automatic fire();
		@(posedge mclk);
		frm_valid <= 1'b1;
		@(posedge mclk);
		frm_valid <= 1'b0;
		#1;
	endtask

	// Bytes past the frame window read as zero
	task automatic chk_raw(input int st);
		for (int b = 0; b < 57; b++) begin
			chk("raw1", raw_key1_data[b*8 +: 8], (st + b < 128) ? frm_data[st+b] : 8'h00);
			if (b < 24) chk("raw2", raw_key2_data[b*8 +: 8], (st + b < 128) ? frm_data[st+b] : 8'h00);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Whole run is under a hundred cycles; a hang is cut well past that
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		close_out();
	end

	initial begin
		sys_rst = 1'b1;
		{frm_valid, control_word_frame, frm_dst_mc, frm_tcp_udp, raw_key_enable, raw_key_position, hit_mask} = '0;
		{lookup_enable, range_type_cfg, lookup_key_choice_cfg, range_bounds_cfg, range_field_offset_cfg} = '0;
		{frm_port, frm_l3_pos, frm_etype_pos, frm_vid, frm_dscp, frm_sport, frm_dport} = '0;
		frm_type = FT_ETYPE;
		for (int i = 0; i < 128; i++) frm_data[i] = 8'(i) + 8'h10;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		lookup_enable <= 24'h000010;
		hit_mask <= 2'h3;
		frm_port <= 4'h2;
		// Key choice per frame type, lookup 0 of port 2 only
		for (int i = 0; i < 12; i++) begin
			@(posedge mclk);
			frm_type <= ft_t[i];
			lookup_key_choice_cfg[14:12] <= ch_t[i];
			fire();
			chk("kind0", key_kind_lk0, kt_t[i]);
			chk("valid", key_valid, 2'h1);
			chk("used", match_used, 2'h1);
		end
		$display("choice test done");
		// Both lookups, then lookup 0 switched off
		@(posedge mclk);
		lookup_enable <= 24'h000030;
		frm_type <= FT_IP4_UC;
		hit_mask <= 2'h2;
		fire();
		chk("valid", key_valid, 2'h3);
		chk("kind1", key_kind_lk1, KT_GENERIC);
		chk("used", match_used, 2'h2);
		@(posedge mclk);
		lookup_enable <= 24'h000020;
		hit_mask <= 2'h3;
		fire();
		chk("valid", key_valid, 2'h2);
		chk("used", match_used, 2'h2);
		$display("enable test done");
		// Eight range checkers on a seven-field key, bounds hit exactly
		@(posedge mclk);
		lookup_enable <= 24'h000010;
		lookup_key_choice_cfg[14:12] <= 3'h3;
		range_type_cfg <= {3'h6, 3'h0, 3'h5, 3'h4, 3'h0, 3'h2, 3'h1, 3'h3};
		range_bounds_cfg <= {32'hffff0000, 32'h012c00c9, 32'h1e1f1e1f, 32'h00070005, {3{32'h00c80064}}, 32'h000a000a};
		range_field_offset_cfg <= 8'h02;
		frm_etype_pos <= 7'h0c;
		{frm_vid, frm_dscp, frm_sport, frm_dport, frm_tcp_udp} <= {12'h00a, 6'h08, 16'h0032, 16'h00c8, 1'b1};
		fire();
		chk("flags", range_flags_field_lk0, 8'h2d);
		chk("flags1", range_flags_field_lk1, 8'h00);
		@(posedge mclk);
		{frm_dscp, frm_tcp_udp} <= {6'h06, 1'b0};
		fire();
		chk("flags", range_flags_field_lk0, 8'h31);
		@(posedge mclk);
		lookup_key_choice_cfg[14:12] <= 3'h0;
		fire();
		chk("flags", range_flags_field_lk0, 8'h00);
		$display("range test done");
		// Raw keys from every start position
		@(posedge mclk);
		raw_key_enable <= 2'h1;
		frm_l3_pos <= 7'h0e;
		for (int p = 0; p < 4; p++) begin
			@(posedge mclk);
			raw_key_position <= 2'(p);
			fire();
			chk("kind0", key_kind_lk0, KT_RAW1);
			chk_raw(p == 0 ? 0 : 14 + (p - 1) * 20);
		end
		@(posedge mclk);
		raw_key_enable <= 2'h2;
		fire();
		chk("kind0", key_kind_lk0, KT_RAW2);
		// Start near the window end, so trailing bytes read as zero
		@(posedge mclk);
		{raw_key_enable, raw_key_position, frm_l3_pos} <= {2'h1, 2'h2, 7'h5a};
		fire();
		chk_raw(110);
		@(posedge mclk);
		frm_l3_pos <= 7'h0e;
		$display("raw test done");
		// Control-word frames keyed by the IP version nibble
		@(posedge mclk);
		raw_key_enable <= 2'h0;
		control_word_frame <= 1'b1;
		lookup_key_choice_cfg[14:12] <= 3'h4;
		for (int n = 0; n < 3; n++) begin
			@(posedge mclk);
			frm_data[14] <= nib_t[n];
			fire();
			chk("valid", key_valid, {1'b0, n < 2});
			if (n < 2) begin
				chk("kind0", key_kind_lk0, kc_t[n]);
				chk("l2zero", key_l2_zero, 1'b1);
			end
		end
		@(posedge mclk);
		raw_key_enable <= 2'h1;
		raw_key_position <= 2'h0;
		fire();
		chk("valid", key_valid, 2'h0);
		@(posedge mclk);
		raw_key_position <= 2'h1;
		fire();
		chk("kind0", key_kind_lk0, KT_RAW1);
		chk("cwraw", raw_key1_data[7:0], 8'h50);
		$display("control word test done");
		close_out();
	end
endmodule
